/* rstc_pkg.sv */
// Radio state transition controller: constants, types and decode functions.
// Assumes a 100 MHz core clock and a 32-bit classic Wishbone register bus.
package rstc_pkg;

   // ==========================================================
   // Clock and rate scaling
   localparam int unsigned CLK_HZ        = 32'h05F5_E100;
   localparam real         CLK_MHZ       = 100.0;
   localparam int unsigned BITS_PER_BYTE = 32'h0000_0008;
   localparam int unsigned RATE_UNIT_BPS = 32'h0000_0064;
   localparam int unsigned BYTE_NUM      = BITS_PER_BYTE * CLK_HZ / RATE_UNIT_BPS;
   localparam int unsigned RAMP_NUM      = CLK_HZ / (2 * RATE_UNIT_BPS);
   localparam logic [3:0]  RAMP_BASE     = 4'h9;

   // ==========================================================
   // Register indices, byte address is four times the index
   localparam logic [9:0] IDX_CTRL      = 10'h000;
   localparam logic [9:0] IDX_CMD       = 10'h001;
   localparam logic [9:0] IDX_STATE     = 10'h002;
   localparam logic [9:0] IDX_IRQ_STAT  = 10'h003;
   localparam logic [9:0] IDX_IRQ_MASK  = 10'h004;
   localparam logic [9:0] IDX_RATE_LOW  = 10'h10C;
   localparam logic [9:0] IDX_RATE_HIGH = 10'h10D;
   localparam logic [9:0] IDX_AMP_RAMP  = 10'h114;

   // Control fields
   localparam int unsigned CTRL_PKT  = 0;
   localparam int unsigned CTRL_FAST = 1;
   localparam int unsigned CTRL_AUTO = 2;

   // Interrupt status fields
   localparam int unsigned IRQ_DONE   = 0;
   localparam int unsigned IRQ_REFUSE = 1;

   // Reset values
   localparam logic [2:0] RST_CTRL      = 3'h0;
   localparam logic [7:0] RST_RATE_LOW  = 8'h60;
   localparam logic [7:0] RST_RATE_HIGH = 8'h00;
   localparam logic [7:0] RST_AMP_RAMP  = 8'h00;
   localparam logic [1:0] RST_IRQ_MASK  = 2'h0;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      cmd_none        = 2'h0,
      cmd_go_idle_on  = 2'h1,
      cmd_go_transmit = 2'h2,
      cmd_go_receive  = 2'h3
   } rstc_cmd_e;

   typedef enum logic [3:0] {
      state_idle_on   = 4'b0001,
      state_transmit  = 4'b0010,
      state_receive   = 4'b0100,
      state_switching = 4'b1000
   } rstc_radio_e;

   typedef enum logic [4:0] {
      amp_off   = 5'b00001,
      amp_delay = 5'b00010,
      amp_up    = 5'b00100,
      amp_full  = 5'b01000,
      amp_down  = 5'b10000
   } rstc_amp_e;

   typedef enum logic [1:0] {
      phase_search   = 2'h0,
      phase_preamble = 2'h1,
      phase_sync     = 2'h2,
      phase_data     = 2'h3
   } rstc_phase_e;

   typedef enum logic [4:0] {
      tr_tx_on, tr_rxs_on, tr_rxq_on, tr_rxd_on,
      tr_on_tx, tr_rxs_tx, tr_rxq_tx, tr_rxd_tx, tr_tx_tx,
      tr_on_rx, tr_tx_rx, tr_rxs_rx, tr_rxq_rx, tr_rxd_rx,
      tr_eof_on, tr_eof_rx, tr_rxeof_on, tr_stay
   } rstc_tr_e;

   localparam int unsigned NT = 18;
   typedef real         rstc_us_t  [NT];
   typedef int unsigned rstc_cyc_t [NT];

   // ==========================================================
   // Transition times, microseconds, in the order of rstc_tr_e
   localparam rstc_us_t T_NORM_US = '{51.0, 54.0, 50.5, 56.0, 306.0, 325.0, 320.0, 326.0,
      315.0, 327.0, 345.0, 342.0, 339.5, 346.0, 25.0, 322.0, 46.0, 0.0};
   localparam rstc_us_t T_FAST_US = '{22.0, 28.0, 23.0, 26.0, 237.0, 250.0, 245.0, 249.0,
      243.0, 241.0, 250.0, 249.5, 249.0, 252.0, 5.0, 232.0, 10.0, 0.0};
   localparam real T_AMP_DELAY_US = 3.4;
   localparam int unsigned AMP_DELAY_CYC = int'(T_AMP_DELAY_US * CLK_MHZ);

   function automatic rstc_cyc_t to_cyc(input rstc_us_t us);
      rstc_cyc_t c;
      for (int i = 0; i < NT; i++) begin
         c[i] = int'(us[i] * CLK_MHZ);
      end
      return c;
   endfunction

   localparam rstc_cyc_t CYC_NORM_DEF = to_cyc(T_NORM_US);
   localparam rstc_cyc_t CYC_FAST_DEF = to_cyc(T_FAST_US);

   // ==========================================================
   // Decode functions
   function automatic rstc_tr_e cmd_index(input rstc_radio_e st, input rstc_cmd_e cmd,
                                          input rstc_phase_e ph);
      logic s;
      logic q;
      logic t;
      s = (ph == phase_search);
      q = (ph == phase_preamble) || (ph == phase_sync);
      t = (st == state_transmit);
      if (cmd == cmd_go_idle_on && st == state_receive) begin
         return s ? tr_rxs_on : (q ? tr_rxq_on : tr_rxd_on);
      end
      if (cmd == cmd_go_transmit && st == state_receive) begin
         return s ? tr_rxs_tx : (q ? tr_rxq_tx : tr_rxd_tx);
      end
      if (cmd == cmd_go_receive && st == state_receive) begin
         return s ? tr_rxs_rx : (q ? tr_rxq_rx : tr_rxd_rx);
      end
      if (cmd == cmd_go_idle_on) begin
         return t ? tr_tx_on : tr_stay;
      end
      if (cmd == cmd_go_transmit) begin
         return t ? tr_tx_tx : tr_on_tx;
      end
      return t ? tr_tx_rx : tr_on_rx;
   endfunction

   function automatic rstc_radio_e target_of(input rstc_cmd_e cmd);
      return (cmd == cmd_go_transmit) ? state_transmit :
             (cmd == cmd_go_receive) ? state_receive : state_idle_on;
   endfunction

   function automatic logic needs_byte(input rstc_tr_e tr);
      return tr inside {tr_rxs_on, tr_rxs_tx, tr_rxs_rx, tr_eof_on, tr_eof_rx};
   endfunction

   function automatic logic needs_ramp(input rstc_tr_e tr);
      return tr inside {tr_tx_on, tr_tx_tx, tr_tx_rx, tr_eof_on, tr_eof_rx};
   endfunction

endpackage

/* rstc_ctrl.sv */
// Radio state transition controller with Wishbone register slave.
// Assumes rx phase and end-of-frame inputs come from logic on mclk_i.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns

module rstc_ctrl
   import rstc_pkg::*;
#(
   parameter rstc_cyc_t CYC_NORM = CYC_NORM_DEF,
   parameter rstc_cyc_t CYC_FAST = CYC_FAST_DEF
) (
   input  wire logic        mclk_i,
   input  wire logic        reset_n_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        tx_eof_i,
   input  wire logic        rx_eof_i,
   input  wire logic [1:0]  rx_phase_i,
   output logic             irq_o,
   output logic      [3:0]  radio_state_o,
   output logic             amp_ramp_up_o,
   output logic             amp_full_o,
   output logic             amp_ramp_down_o
);

   // ==========================================================
   // State
   logic        ack_q;
   logic [31:0] dat_q;
   logic [2:0]  ctrl_q;
   logic [7:0]  rate_lo_q;
   logic [7:0]  rate_hi_q;
   logic [7:0]  ramp_q;
   logic [1:0]  mask_q;
   logic [1:0]  stat_q;
   logic        irq_q;
   rstc_radio_e radio_q;
   rstc_radio_e radio_d;
   rstc_radio_e tgt_q;
   logic [23:0] cnt_q;
   rstc_amp_e   amp_q;
   rstc_amp_e   amp_d;
   logic [23:0] amp_cnt_q;
   logic [23:0] amp_cnt_d;

   // ==========================================================
   // Bus decode
   wire         wb_req    = wb_cyc_i & wb_stb_i & ~ack_q;
   wire         wb_wr     = wb_req & wb_we_i & wb_sel_i[0];
   wire [9:0]   reg_idx   = wb_adr_i[11:2];
   wire         hit_ctrl  = (reg_idx == IDX_CTRL);
   wire         hit_cmd   = (reg_idx == IDX_CMD);
   wire         hit_state = (reg_idx == IDX_STATE);
   wire         hit_stat  = (reg_idx == IDX_IRQ_STAT);
   wire         hit_mask  = (reg_idx == IDX_IRQ_MASK);
   wire         hit_rlo   = (reg_idx == IDX_RATE_LOW);
   wire         hit_rhi   = (reg_idx == IDX_RATE_HIGH);
   wire         hit_ramp  = (reg_idx == IDX_AMP_RAMP);
   wire [31:0]  rd_data   =
      hit_ctrl  ? {29'h0, ctrl_q} :
      hit_state ? {23'h0, amp_q, radio_q} :
      hit_stat  ? {30'h0, stat_q} :
      hit_mask  ? {30'h0, mask_q} :
      hit_rlo   ? {24'h0, rate_lo_q} :
      hit_rhi   ? {24'h0, rate_hi_q} :
      hit_ramp  ? {24'h0, ramp_q} : 32'h0;

   // ==========================================================
   // Command and event selection
   wire         pkt_mode  = ctrl_q[CTRL_PKT];
   wire         fast_mode = ctrl_q[CTRL_FAST];
   wire         auto_tx_then_rx = ctrl_q[CTRL_AUTO];
   rstc_cmd_e   cmd_code;
   rstc_phase_e rx_phase;
   assign cmd_code = rstc_cmd_e'(wb_dat_i[1:0]);
   assign rx_phase = rstc_phase_e'(rx_phase_i);
   wire         busy      = (radio_q == state_switching);
   wire         cmd_wr    = wb_wr & hit_cmd & (cmd_code != cmd_none);
   wire         cmd_take  = cmd_wr & ~busy;
   wire         cmd_refuse = cmd_wr & busy;
   wire         tx_end    = tx_eof_i & pkt_mode & (radio_q == state_transmit) & ~cmd_wr;
   wire         rx_end    = rx_eof_i & pkt_mode & (radio_q == state_receive) & ~cmd_wr;
   wire         start     = cmd_take | tx_end | rx_end;

   rstc_tr_e    tr_idx;
   rstc_radio_e tgt_d;
   assign tr_idx = cmd_take ? cmd_index(radio_q, cmd_code, rx_phase) :
                   tx_end ? (auto_tx_then_rx ? tr_eof_rx : tr_eof_on) :
                   tr_rxeof_on;
   assign tgt_d  = cmd_take ? target_of(cmd_code) :
                   (tx_end & auto_tx_then_rx) ? state_receive : state_idle_on;

   // ==========================================================
   // Transition time
   wire [15:0]  rate      = {rate_hi_q, rate_lo_q};
   wire [15:0]  rate_nz   = (rate == 16'h0) ? 16'h0001 : rate;
   wire [2:0]   ramp_set  = ramp_q[2:0];
   wire [23:0]  byte_cyc  = 24'(BYTE_NUM / rate_nz);
   wire [23:0]  ramp_cyc  = 24'(((RAMP_BASE - ramp_set) * RAMP_NUM) / rate_nz);
   wire [23:0]  base_cyc  = 24'(fast_mode ? CYC_FAST[tr_idx] : CYC_NORM[tr_idx]);
   wire [23:0]  total_cyc = base_cyc
                          + (needs_byte(tr_idx) ? byte_cyc : 24'h0)
                          + (needs_ramp(tr_idx) ? ramp_cyc : 24'h0);
   wire [23:0]  load_cyc  = (total_cyc == 24'h0) ? 24'h000001 : total_cyc;
   wire         done      = busy & (cnt_q == 24'h000001);

   // ==========================================================
   // Radio state machine
   always_comb begin
      radio_d = radio_q;
      unique case (radio_q)
         state_idle_on,
         state_transmit,
         state_receive: begin
            if (start) begin
               radio_d = state_switching;
            end
         end
         state_switching: begin
            if (done) begin
               radio_d = tgt_q;
            end
         end
      endcase
   end

   // ==========================================================
   // Amplifier sequencing
   wire leave_tx = start & (radio_q == state_transmit);
   wire enter_tx = done & (tgt_q == state_transmit);
   wire amp_end  = (amp_cnt_q == 24'h000001);

   always_comb begin
      amp_d     = amp_q;
      amp_cnt_d = (amp_cnt_q != 24'h0) ? amp_cnt_q - 24'h000001 : 24'h0;
      if (leave_tx) begin
         amp_d     = (amp_q == amp_up || amp_q == amp_full) ? amp_down : amp_off;
         amp_cnt_d = ramp_cyc;
      end else if (enter_tx) begin
         amp_d     = amp_delay;
         amp_cnt_d = 24'(AMP_DELAY_CYC);
      end else begin
         unique case (amp_q)
            amp_delay: begin
               if (amp_end) begin
                  amp_d     = amp_up;
                  amp_cnt_d = ramp_cyc;
               end
            end
            amp_up: begin
               if (amp_end) begin
                  amp_d = amp_full;
               end
            end
            amp_down: begin
               if (amp_end) begin
                  amp_d = amp_off;
               end
            end
            amp_off,
            amp_full: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Interrupt status, set wins over clear
   wire [1:0] stat_set = {cmd_refuse, done};
   wire [1:0] stat_clr = (wb_wr & hit_stat) ? wb_dat_i[1:0] : 2'h0;
   wire [1:0] stat_d   = (stat_q & ~stat_clr) | stat_set;
   wire [1:0] mask_d   = (wb_wr & hit_mask) ? wb_dat_i[1:0] : mask_q;

   // ==========================================================
   // Registers
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end else begin
         ack_q <= wb_req;
         if (wb_req) begin
            dat_q <= rd_data;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_q    <= RST_CTRL;
         rate_lo_q <= RST_RATE_LOW;
         rate_hi_q <= RST_RATE_HIGH;
         ramp_q    <= RST_AMP_RAMP;
      end else if (wb_wr) begin
         if (hit_ctrl) begin
            ctrl_q <= wb_dat_i[2:0];
         end
         if (hit_rlo) begin
            rate_lo_q <= wb_dat_i[7:0];
         end
         if (hit_rhi) begin
            rate_hi_q <= wb_dat_i[7:0];
         end
         if (hit_ramp) begin
            ramp_q <= wb_dat_i[7:0];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mask_q <= RST_IRQ_MASK;
         stat_q <= 2'h0;
         irq_q  <= 1'b0;
      end else begin
         mask_q <= mask_d;
         stat_q <= stat_d;
         irq_q  <= |(stat_d & mask_d);
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         radio_q <= state_idle_on;
         tgt_q   <= state_idle_on;
         cnt_q   <= 24'h0;
      end else begin
         radio_q <= radio_d;
         if (start) begin
            tgt_q <= tgt_d;
            cnt_q <= load_cyc;
         end else if (cnt_q != 24'h0) begin
            cnt_q <= cnt_q - 24'h000001;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         amp_q     <= amp_off;
         amp_cnt_q <= 24'h0;
      end else begin
         amp_q     <= amp_d;
         amp_cnt_q <= amp_cnt_d;
      end
   end

   // ==========================================================
   // Outputs
   assign wb_ack_o        = ack_q;
   assign wb_dat_o        = dat_q;
   assign irq_o           = irq_q;
   assign radio_state_o   = radio_q;
   assign amp_ramp_up_o   = amp_q[2];
   assign amp_full_o      = amp_q[3];
   assign amp_ramp_down_o = amp_q[4];

endmodule // rstc_ctrl

/* rstc_monitor.sv */
// Concurrent checks on the ports of the radio state controller.
// Assumes it is bound to rstc_ctrl and sees only that module's ports.
`timescale 1ns/1ns
module rstc_monitor
   import rstc_pkg::*;
(
   input wire logic        mclk_i,
   input wire logic        reset_n_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        irq_o,
   input wire logic [3:0]  radio_state_o,
   input wire logic        amp_ramp_up_o,
   input wire logic        amp_full_o,
   input wire logic        amp_ramp_down_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   // ==========================================================
   // Sequences
   sequence seq_cmd_write;
      wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[11:2] == IDX_CMD
         && wb_dat_i[1:0] != 2'h0 && radio_state_o != state_switching;
   endsequence
   sequence seq_tx_entry;
      $rose(radio_state_o == state_transmit);
   endsequence
   // ==========================================================
   // Assertions
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged in next cycle");
   chk_cmd_read_zero: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
      && wb_adr_i[11:2] == IDX_CMD |=> wb_dat_o == 32'h0000_0000)
      else $error("command register read not zero");
   chk_cmd_starts: assert property (
      seq_cmd_write |=> radio_state_o == state_switching)
      else $error("command did not start a transition");
   chk_state_onehot: assert property ($onehot(radio_state_o))
      else $error("radio state not one-hot");
   chk_ramp_delay: assert property (seq_tx_entry |->
      ##300 ##39 !amp_ramp_up_o ##1 amp_ramp_up_o)
      else $error("ramp up not 340 cycles after entry");
   chk_amp_onehot: assert property (
      $onehot0({amp_ramp_up_o, amp_full_o, amp_ramp_down_o}))
      else $error("amplifier flags overlap");
   chk_up_to_full: assert property ($fell(amp_ramp_up_o)
      && radio_state_o == state_transmit |-> amp_full_o)
      else $error("ramp up not followed by full power");
   chk_full_to_down: assert property (
      $fell(amp_full_o) |-> amp_ramp_down_o)
      else $error("full power left without ramp down");
   chk_switch_ends: assert property ($rose(radio_state_o == state_switching)
      |-> ##[1:1000] radio_state_o != state_switching)
      else $error("transition never finished");
endmodule // rstc_monitor

bind rstc_ctrl rstc_monitor u_mon (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
   .radio_state_o(radio_state_o), .amp_ramp_up_o(amp_ramp_up_o), .amp_full_o(amp_full_o),
   .amp_ramp_down_o(amp_ramp_down_o));

/* rstc_host.sv */
// Host processor model: classic Wishbone master and command sequencing.
// Assumes one clock shared with the controller and a level interrupt.
`timescale 1ns/1ns
module rstc_host (
   input  wire logic        mclk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i,
   input  wire logic        irq_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic      [11:0] adr_o,
   output logic      [3:0]  sel_o,
   output logic      [31:0] dat_o
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 12'hFFF;
      sel_o = 4'h0;
      dat_o = 32'h0000_0000;
   end
   // ==========================================================
   // Bus cycle, released address and data lines show inverted values
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge mclk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      dat_o <= d;
      sel_o <= 4'hF;
      do @(posedge mclk_i); while (ack_i !== 1'b1);
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      adr_o <= ~a;
      dat_o <= ~d;
   endtask
   // ==========================================================
   // Commands wait for the done interrupt
   task automatic wait_done(inout int n);
      #1;
      while (irq_i !== 1'b1 && n < 5000) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
   endtask
   task automatic cmd(input logic [1:0] c, output int n);
      logic [31:0] q;
      xfer(1'b1, 12'h004, {30'h0, c}, q);
      n = 1;
      wait_done(n);
   endtask
endmodule // rstc_host

/* rstc_ctrl_bench.sv */
// Testbench for the radio state controller: register and timing tests.
// Assumes rstc_host as bus master and shortened transition tables.
`timescale 1ns/1ns
module rstc_ctrl_bench
   import rstc_pkg::*;
;
   localparam int RATE   = 65535;
   localparam int BYTE_C = 8000000 / RATE;
   localparam int RAMP_C = ((9 - 4) * 500000) / RATE;
   function automatic rstc_cyc_t mk(input int b);
      rstc_cyc_t c;
      for (int i = 0; i < NT; i++) c[i] = b + 3 * i;
      c[NT-1] = 0;
      return c;
   endfunction
   localparam rstc_cyc_t CN = mk(40);
   localparam rstc_cyc_t CF = mk(20);
   logic        mclk_i    = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        tx_eof    = 1'b0;
   logic        rx_eof    = 1'b0;
   logic [1:0]  rx_phase  = 2'h0;
   logic        cyc, stb, we, ack, irq, up, full, down;
   logic [11:0] adr;
   logic [3:0]  sel, st, ex;
   logic [31:0] wdat, rdat, q;
   int          errors       = 0;
   int          total_checks = 0;
   int          n, e;
   int          stp [27][5] = '{'{2,0,4,0,0}, '{2,0,8,2,0}, '{3,0,10,2,0}, '{3,0,11,1,0},
      '{3,3,13,0,0}, '{2,1,6,0,0}, '{1,0,0,2,0}, '{3,0,9,0,0}, '{1,2,2,0,0}, '{1,0,17,0,0},
      '{2,0,4,0,2}, '{1,0,0,2,2}, '{2,0,4,0,1}, '{4,0,14,3,1}, '{2,0,4,0,5}, '{4,0,15,3,5},
      '{5,0,16,0,5}, '{3,0,9,0,0}, '{1,0,1,1,0}, '{3,0,9,0,0}, '{2,3,7,0,0}, '{3,0,10,2,0},
      '{1,3,3,0,0}, '{3,0,9,0,0}, '{2,0,5,1,0}, '{3,0,10,2,0}, '{3,2,12,0,0}};
   logic [11:0] ra [9] = '{12'h000, 12'h008, 12'h00C, 12'h010, 12'h430, 12'h434, 12'h450,
      12'h004, 12'h0FC};
   logic [31:0] rv [9] = '{32'h0, 32'h11, 32'h0, 32'h0, 32'h60, 32'h0, 32'h0, 32'h0, 32'h0};

   always #5 mclk_i = ~mclk_i;

   rstc_ctrl #(.CYC_NORM(CN), .CYC_FAST(CF)) uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_eof_i(tx_eof), .rx_eof_i(rx_eof),
      .rx_phase_i(rx_phase), .irq_o(irq), .radio_state_o(st), .amp_ramp_up_o(up),
      .amp_full_o(full), .amp_ramp_down_o(down));
   rstc_host host (.mclk_i(mclk_i), .ack_i(ack), .dat_i(rdat), .irq_i(irq), .cyc_o(cyc),
      .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

   // ==========================================================
   // Checking and closing
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge mclk_i);
      errors++;
      $display("ERROR %0t watchdog expired", $time);
      stop_test();
   end

   // ==========================================================
   // Tests
   initial begin
      repeat (16) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         host.xfer(1'b0, ra[i], 32'h0, q);
         check(q, rv[i]);
      end
      $display("reset values done");
      host.xfer(1'b1, 12'h430, 32'hFF, q);
      host.xfer(1'b1, 12'h434, 32'hFF, q);
      host.xfer(1'b1, 12'h450, 32'h4, q);
      host.xfer(1'b1, 12'h004, 32'h1, q);
      repeat (3) @(posedge mclk_i);
      #1 check(irq, 1'b0);
      host.xfer(1'b0, 12'h00C, 32'h0, q);
      check(q, 32'h1);
      host.xfer(1'b1, 12'h010, 32'h1, q);
      repeat (2) @(posedge mclk_i);
      #1 check(irq, 1'b1);
      host.xfer(1'b1, 12'h00C, 32'h1, q);
      $display("interrupt mask done");
      for (int s = 0; s < 27; s++) begin
         host.xfer(1'b1, 12'h000, stp[s][4], q);
         @(posedge mclk_i) rx_phase <= 2'(stp[s][1]);
         if (stp[s][0] < 4) begin
            host.cmd(2'(stp[s][0]), n);
         end else begin
            @(posedge mclk_i);
            tx_eof <= (stp[s][0] == 4);
            rx_eof <= (stp[s][0] == 5);
            @(posedge mclk_i);
            tx_eof <= 1'b0;
            rx_eof <= 1'b0;
            n = 0;
            host.wait_done(n);
         end
         e = (stp[s][4][1] ? CF[stp[s][2]] : CN[stp[s][2]]) + (stp[s][3][0] ? BYTE_C : 0)
            + (stp[s][3][1] ? RAMP_C : 0);
         if (e < 1) e = 1;
         check(n, e);
         host.xfer(1'b0, 12'h008, 32'h0, q);
         ex = (stp[s][0] == 3 || (stp[s][0] == 4 && stp[s][4] == 5)) ? 4'h4 : 4'h1;
         if (stp[s][0] == 2) begin
            ex = 4'h2;
         end
         check(q[3:0], ex);
         host.xfer(1'b1, 12'h00C, 32'h1, q);
         repeat (500) @(posedge mclk_i);
         #1 check(irq, 1'b0);
         check(st, ex);
         check({up, full, down}, (ex == 4'h2) ? 3'b010 : 3'b000);
         $display("step %0d done", s);
      end
      // Command while switching is refused and flagged
      host.xfer(1'b1, 12'h010, 32'h3, q);
      host.xfer(1'b1, 12'h004, 32'h2, q);
      host.xfer(1'b1, 12'h004, 32'h1, q);
      host.xfer(1'b0, 12'h00C, 32'h0, q);
      check(q, 32'h2);
      #1 check(irq, 1'b1);
      host.xfer(1'b0, 12'h008, 32'h0, q);
      check(q, 32'h18);
      host.xfer(1'b1, 12'h00C, 32'h2, q);
      n = 0;
      host.wait_done(n);
      host.xfer(1'b0, 12'h008, 32'h0, q);
      check(q[3:0], 4'h2);
      $display("refused command done");
      stop_test();
   end
endmodule // rstc_ctrl_bench
